// [core/ccs_pkg.sv]
// constants for the core state and stack block
// assumes a single core clock domain; data space is byte wide
package ccs_pkg;
    localparam logic [7:0]  ADDR_PTR_FIRST   = 8'h80;
    localparam logic [7:0]  ADDR_PTR_SECOND  = 8'h81;
    localparam logic [7:0]  ADDR_SHORT_FIRST = 8'h82;
    localparam logic [7:0]  ADDR_SHORT_SECOND = 8'h83;
    localparam logic [7:0]  ADDR_ACCUM       = 8'hff;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;
    localparam logic [11:0] RESET_PC         = 12'h000;
    localparam int          PC_WIDTH         = 12;
    localparam int          STACK_DEPTH      = 6;
    localparam int          PERIPH_DIV       = 12;
    localparam int          CORE_DIV         = 13;
    localparam logic [3:0]  DIV_ZERO         = 4'h0;
    localparam logic [2:0]  STACK_EMPTY      = 3'h0;

    // program counter update source
    typedef enum logic [6:0] {
        CCS_PC_HOLD  = 7'h01,
        CCS_PC_INC   = 7'h02,
        CCS_PC_JUMP  = 7'h04,
        CCS_PC_CALL  = 7'h08,
        CCS_PC_REL   = 7'h10,
        CCS_PC_VEC   = 7'h20,
        CCS_PC_RET   = 7'h40
    } ccs_pcop_t;

    // flag context in use
    typedef enum logic [2:0] {
        CCS_MODE_NORMAL = 3'h1,
        CCS_MODE_IRQ    = 3'h2,
        CCS_MODE_NMI    = 3'h4
    } ccs_mode_t;

    // alu operation kinds that touch the flags
    typedef enum logic [4:0] {
        CCS_FL_NONE  = 5'h01,
        CCS_FL_ARITH = 5'h02,
        CCS_FL_LOGIC = 5'h04,
        CCS_FL_BTEST = 5'h08,
        CCS_FL_ROTL  = 5'h10
    } ccs_flop_t;
endpackage

// [core/ccs_clock_divider.sv]
// clock divider producing one-cycle ticks for peripherals and core
// assumes core_clk is the internal clock and sys_rst is synchronous
`timescale 1ns/1ns
`default_nettype none
module ccs_clock_divider #(
    parameter int PERIPH_DIV = ccs_pkg::PERIPH_DIV,
    parameter int CORE_DIV   = ccs_pkg::CORE_DIV
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    output logic      periphTick,
    output logic      machineTick
);
    logic [3:0] periphCnt_r;
    logic [3:0] coreCnt_r;

    // divide by twelve for timer, converter and watchdog
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            periphCnt_r <= ccs_pkg::DIV_ZERO;
            periphTick  <= 1'b0;
        end else begin
            periphTick <= (periphCnt_r == 4'(PERIPH_DIV - 1)); // [RQ19]
            if (periphCnt_r == 4'(PERIPH_DIV - 1)) begin
                periphCnt_r <= ccs_pkg::DIV_ZERO;
            end else begin
                periphCnt_r <= periphCnt_r + 4'h1;
            end
        end
    end

    // divide by thirteen for the machine cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            coreCnt_r   <= ccs_pkg::DIV_ZERO;
            machineTick <= 1'b0;
        end else begin
            machineTick <= (coreCnt_r == 4'(CORE_DIV - 1)); // [RQ19]
            if (coreCnt_r == 4'(CORE_DIV - 1)) begin
                coreCnt_r <= ccs_pkg::DIV_ZERO;
            end else begin
                coreCnt_r <= coreCnt_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [core/ccs_core_state.sv]
// architectural state of the core: data registers, pc, flags, stack
// assumes the sequencer drives one pc operation per machine cycle tick
//
// What this block does
// [RQ1] 8-bit accumulator used by alu, also data-space location ffh
// [RQ2] two pointer registers at data-space locations 80h and 81h
// [RQ3] two short-direct registers at data-space locations 82h and 83h
// [RQ4] program counter is twelve bits, spanning 4096 program bytes
// [RQ5] pc loads jump, call, relative, vector, popped value, or increments
// [RQ6] pc increments after each instruction address is read
// [RQ7] relative branch adds pc and offset through the alu
// [RQ8] three carry/zero pairs; arithmetic uses the current mode's pair
// [RQ9] interrupt entry selects irq or nmi pair; return restores prior
// [RQ10] switching pairs never clears any flag
// [RQ11] only the current context's flag pair is visible or writable
// [RQ12] carry from carry/borrow, bit test loads carry, rotate-left uses it
// [RQ13] zero set when last arithmetic or logic result is zero
// [RQ14] after reset the core runs in nmi mode with nmi flags
// [RQ15] six-entry 12-bit return stack; push shifts deeper, pc to level one
// [RQ16] pop loads level one into pc and moves deeper entries up
// [RQ17] push on full stack drops the sixth level value
// [RQ18] pop on empty stack keeps it at top; execution continues in order
// [RQ19] internal clock divided by 12 for peripherals, 13 for core
// [RQ20] instructions take two, four or five machine cycles
// [RQ21] nmi over irq selects nmi pair; its return reselects irq pair
`timescale 1ns/1ns
`default_nettype none
module ccs_core_state #(
    parameter int DEPTH = ccs_pkg::STACK_DEPTH
) (
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    input  wire logic                cycleDone,
    input  wire logic [2:0]          instrCycles,
    input  wire ccs_pkg::ccs_pcop_t  pcOp,
    input  wire logic [11:0]         pcTarget,
    input  wire logic [7:0]          relOffset,
    input  wire logic                enterIrq,
    input  wire logic                enterNmi,
    input  wire logic                isReti,
    input  wire logic                dataWrEn,
    input  wire logic [7:0]          dataAddr,
    input  wire logic [7:0]          dataWrData,
    input  wire logic                accWrEn,
    input  wire logic [7:0]          accWrData,
    input  wire ccs_pkg::ccs_flop_t  flagOp,
    input  wire logic [7:0]          aluResult,
    input  wire logic                aluCarry,
    input  wire logic                testedBit,
    output logic [7:0]               dataRdData,
    output logic                     dataHit,
    output logic [7:0]               accumulator,
    output logic [7:0]               pointerFirst,
    output logic [7:0]               pointerSecond,
    output logic [11:0]              programCounter,
    output logic                     carryFlag,
    output logic                     zeroFlag,
    output ccs_pkg::ccs_mode_t       modeOut,
    output logic                     stackFull,
    output logic                     stackEmpty,
    output logic                     machineTick,
    output logic                     periphTick,
    output logic                     instrDone
);
    logic [7:0]  acc_r, ptrFirst_r, ptrSecond_r, shortFirst_r, shortSecond_r;
    logic [11:0] pc_r, pc_nxt;
    logic [11:0] stack_r [DEPTH];
    logic [2:0]  level_r;
    logic [2:0]  modeStackLvl_r;
    ccs_pkg::ccs_mode_t mode_r, mode_nxt;
    ccs_pkg::ccs_mode_t modeHist_r [DEPTH];
    logic [2:0]  carry_r, zero_r;
    logic [2:0]  cycleCnt_r;
    logic        push, pop, tickInt;
    logic        carry_nxt, zero_nxt;

    // one-hot mode code doubles as the index mask of the flag pair
    function automatic logic [2:0] modeMask(input ccs_pkg::ccs_mode_t m);
        return 3'(m);
    endfunction

    // relative offset is signed; the add is the alu's pc path
    function automatic logic [11:0] relTarget(input logic [11:0] pc,
                                              input logic [7:0]  off);
        return pc + {{4{off[7]}}, off}; // [RQ7]
    endfunction

    ccs_clock_divider u_div (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .periphTick  (periphTick),
        .machineTick (tickInt)
    );

    assign push = cycleDone && (pcOp == ccs_pkg::CCS_PC_CALL
                                || pcOp == ccs_pkg::CCS_PC_VEC && !sys_rst);
    assign pop  = cycleDone && pcOp == ccs_pkg::CCS_PC_RET;

    // next program counter selection
    always_comb begin
        pc_nxt = pc_r;
        unique case (pcOp)
            ccs_pkg::CCS_PC_HOLD: pc_nxt = pc_r;
            ccs_pkg::CCS_PC_INC:  pc_nxt = pc_r + 12'h001; // [RQ6]
            ccs_pkg::CCS_PC_JUMP: pc_nxt = pcTarget; // [RQ5]
            ccs_pkg::CCS_PC_CALL: pc_nxt = pcTarget; // [RQ5]
            ccs_pkg::CCS_PC_REL:  pc_nxt = relTarget(pc_r, relOffset); // [RQ7]
            ccs_pkg::CCS_PC_VEC:  pc_nxt = pcTarget; // [RQ5]
            ccs_pkg::CCS_PC_RET: begin
                // empty stack: fall through to the next instruction
                if (level_r == ccs_pkg::STACK_EMPTY) begin
                    pc_nxt = pc_r + 12'h001; // [RQ18]
                end else begin
                    pc_nxt = stack_r[0]; // [RQ16]
                end
            end
            default: pc_nxt = pc_r;
        endcase
    end

    // program counter register, twelve bits wraps inside its own space
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pc_r <= ccs_pkg::RESET_PC; // [RQ4]
        end else if (cycleDone) begin
            pc_r <= pc_nxt; // [RQ5]
        end
    end

    // return stack: shift deeper on push, shift up on pop
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level_r <= ccs_pkg::STACK_EMPTY;
            for (int i = 0; i < DEPTH; i++) begin
                stack_r[i] <= ccs_pkg::RESET_PC;
            end
        end else if (push) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                stack_r[i] <= stack_r[i-1]; // [RQ17]
            end
            // return address is the pc of the following instruction
            stack_r[0] <= pc_r; // [RQ15]
            if (level_r != 3'(DEPTH)) begin
                level_r <= level_r + 3'h1;
            end
        end else if (pop && level_r != ccs_pkg::STACK_EMPTY) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                stack_r[i] <= stack_r[i+1]; // [RQ16]
            end
            stack_r[DEPTH-1] <= ccs_pkg::RESET_PC;
            level_r <= level_r - 3'h1;
        end
    end

    // mode selection; history of modes nests with the stack
    always_comb begin
        mode_nxt = mode_r;
        if (cycleDone && enterNmi) begin
            mode_nxt = ccs_pkg::CCS_MODE_NMI; // [RQ9] [RQ21]
        end else if (cycleDone && enterIrq) begin
            mode_nxt = ccs_pkg::CCS_MODE_IRQ; // [RQ9]
        end else if (cycleDone && isReti && modeStackLvl_r != 3'h0) begin
            mode_nxt = modeHist_r[0]; // [RQ9] [RQ21]
        end
    end

    // remembered mode per interrupt level; nmi from reset has no parent
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_r         <= ccs_pkg::CCS_MODE_NMI; // [RQ14]
            modeStackLvl_r <= 3'h0;
            for (int i = 0; i < DEPTH; i++) begin
                modeHist_r[i] <= ccs_pkg::CCS_MODE_NORMAL;
            end
        end else begin
            mode_r <= mode_nxt;
            if (cycleDone && (enterNmi || enterIrq)) begin
                for (int i = DEPTH - 1; i > 0; i--) begin
                    modeHist_r[i] <= modeHist_r[i-1];
                end
                modeHist_r[0] <= mode_r;
                if (modeStackLvl_r != 3'(DEPTH)) begin
                    modeStackLvl_r <= modeStackLvl_r + 3'h1;
                end
            end else if (cycleDone && isReti && modeStackLvl_r != 3'h0) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    modeHist_r[i] <= modeHist_r[i+1];
                end
                modeStackLvl_r <= modeStackLvl_r - 3'h1;
            end
        end
    end

    // flag update for the current pair only
    always_comb begin
        carry_nxt = |(carry_r & modeMask(mode_r)); // [RQ11]
        zero_nxt  = |(zero_r & modeMask(mode_r)); // [RQ11]
        unique case (flagOp)
            ccs_pkg::CCS_FL_NONE: ;
            ccs_pkg::CCS_FL_ARITH: begin
                carry_nxt = aluCarry; // [RQ12]
                zero_nxt  = (aluResult == 8'h00); // [RQ13]
            end
            ccs_pkg::CCS_FL_LOGIC: zero_nxt = (aluResult == 8'h00); // [RQ13]
            ccs_pkg::CCS_FL_BTEST: carry_nxt = testedBit; // [RQ12]
            ccs_pkg::CCS_FL_ROTL: begin
                carry_nxt = aluCarry; // [RQ12]
                zero_nxt  = (aluResult == 8'h00); // [RQ13]
            end
            default: ;
        endcase
    end

    // banked flags: other pairs keep their bits through any switch
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            carry_r <= 3'h0;
            zero_r  <= 3'h0;
        end else if (cycleDone && flagOp != ccs_pkg::CCS_FL_NONE) begin
            for (int i = 0; i < 3; i++) begin
                // one-hot mode bit picks the pair; a call result cannot be indexed
                if (mode_r[i]) begin
                    carry_r[i] <= carry_nxt; // [RQ8] [RQ10]
                    zero_r[i]  <= zero_nxt; // [RQ8] [RQ10]
                end
            end
        end
    end

    // data-space registers; an alu write to the accumulator wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc_r         <= ccs_pkg::RESET_BYTE;
            ptrFirst_r    <= ccs_pkg::RESET_BYTE;
            ptrSecond_r   <= ccs_pkg::RESET_BYTE;
            shortFirst_r  <= ccs_pkg::RESET_BYTE;
            shortSecond_r <= ccs_pkg::RESET_BYTE;
        end else begin
            if (accWrEn) begin
                acc_r <= accWrData; // [RQ1]
            end else if (dataWrEn && dataAddr == ccs_pkg::ADDR_ACCUM) begin
                acc_r <= dataWrData; // [RQ1]
            end
            if (dataWrEn && dataAddr == ccs_pkg::ADDR_PTR_FIRST) begin
                ptrFirst_r <= dataWrData; // [RQ2]
            end
            if (dataWrEn && dataAddr == ccs_pkg::ADDR_PTR_SECOND) begin
                ptrSecond_r <= dataWrData; // [RQ2]
            end
            if (dataWrEn && dataAddr == ccs_pkg::ADDR_SHORT_FIRST) begin
                shortFirst_r <= dataWrData; // [RQ3]
            end
            if (dataWrEn && dataAddr == ccs_pkg::ADDR_SHORT_SECOND) begin
                shortSecond_r <= dataWrData; // [RQ3]
            end
        end
    end

    // registered read port; misses read zero so ram can own the bus
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dataRdData <= ccs_pkg::RESET_BYTE;
            dataHit    <= 1'b0;
        end else begin
            dataHit <= 1'b1;
            unique case (dataAddr)
                ccs_pkg::ADDR_ACCUM:        dataRdData <= acc_r; // [RQ1]
                ccs_pkg::ADDR_PTR_FIRST:    dataRdData <= ptrFirst_r; // [RQ2]
                ccs_pkg::ADDR_PTR_SECOND:   dataRdData <= ptrSecond_r; // [RQ2]
                ccs_pkg::ADDR_SHORT_FIRST:  dataRdData <= shortFirst_r; // [RQ3]
                ccs_pkg::ADDR_SHORT_SECOND: dataRdData <= shortSecond_r; // [RQ3]
                default: begin
                    dataRdData <= ccs_pkg::RESET_BYTE;
                    dataHit    <= 1'b0;
                end
            endcase
        end
    end

    // machine cycle counter within an instruction
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cycleCnt_r <= 3'h0;
            instrDone  <= 1'b0;
        end else begin
            instrDone <= 1'b0;
            if (tickInt) begin
                // only 2, 4 and 5 are legal; others are treated as 2
                if (cycleCnt_r + 3'h1 >= ((instrCycles == 3'h4
                        || instrCycles == 3'h5) ? instrCycles : 3'h2)) begin
                    cycleCnt_r <= 3'h0; // [RQ20]
                    instrDone  <= 1'b1;
                end else begin
                    cycleCnt_r <= cycleCnt_r + 3'h1;
                end
            end
        end
    end

    // registered copies of the visible state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            accumulator    <= ccs_pkg::RESET_BYTE;
            pointerFirst   <= ccs_pkg::RESET_BYTE;
            pointerSecond  <= ccs_pkg::RESET_BYTE;
            programCounter <= ccs_pkg::RESET_PC;
            carryFlag      <= 1'b0;
            zeroFlag       <= 1'b0;
            modeOut        <= ccs_pkg::CCS_MODE_NMI;
            stackFull      <= 1'b0;
            stackEmpty     <= 1'b1;
            machineTick    <= 1'b0;
        end else begin
            accumulator    <= acc_r;
            pointerFirst   <= ptrFirst_r;
            pointerSecond  <= ptrSecond_r;
            programCounter <= pc_r;
            carryFlag      <= |(carry_r & modeMask(mode_r)); // [RQ11]
            zeroFlag       <= |(zero_r & modeMask(mode_r)); // [RQ11]
            modeOut        <= mode_r;
            stackFull      <= (level_r == 3'(DEPTH));
            stackEmpty     <= (level_r == ccs_pkg::STACK_EMPTY);
            machineTick    <= tickInt;
        end
    end
endmodule
`default_nettype wire

// [dv/ccs_vector_rom.sv]
// program memory vector table
// assumes vectors sit at fixed locations
`timescale 1ns/1ns
`default_nettype none
module ccs_vector_rom #(
    parameter logic [11:0] IRQ_VEC = 12'hff0,
    parameter logic [11:0] NMI_VEC = 12'hffc
) (
    output logic [11:0] irqVector,
    output logic [11:0] nmiVector
);
    // fixed vector locations
    assign irqVector = IRQ_VEC;
    assign nmiVector = NMI_VEC;
endmodule
`default_nettype wire

// [dv/ccs_core_state_chk.sv]
// port assertions for the core state and stack block
// assumes one clock domain and state shown two edges after a commit
`timescale 1ns/1ns
`default_nettype none
module ccs_core_state_chk #(
    parameter int DEPTH = ccs_pkg::STACK_DEPTH
) (
    input wire logic               core_clk,
    input wire logic               sys_rst,
    input wire logic               cycleDone,
    input wire ccs_pkg::ccs_pcop_t pcOp,
    input wire logic [11:0]        pcTarget,
    input wire logic [7:0]         relOffset,
    input wire logic               enterIrq,
    input wire logic               enterNmi,
    input wire logic               isReti,
    input wire logic [7:0]         dataAddr,
    input wire ccs_pkg::ccs_flop_t flagOp,
    input wire logic [7:0]         aluResult,
    input wire logic               aluCarry,
    input wire logic               testedBit,
    input wire logic [7:0]         dataRdData,
    input wire logic               dataHit,
    input wire logic [11:0]        programCounter,
    input wire logic               carryFlag,
    input wire logic               zeroFlag,
    input wire ccs_pkg::ccs_mode_t modeOut,
    input wire logic               stackFull,
    input wire logic               machineTick,
    input wire logic               periphTick
);
    logic        mapped;
    logic [11:0] relExt;
    logic        noSwitch;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // helper terms; offset sign-extended
    assign mapped = dataAddr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    assign relExt = {{4{relOffset[7]}}, relOffset};
    assign noSwitch = !enterIrq && !enterNmi && !isReti;
    a_jump_loads_pc: assert property (cycleDone && pcOp == ccs_pkg::CCS_PC_JUMP
        |-> ##2 programCounter == $past(pcTarget, 2))
        else $error("jump not loaded");
    a_inc_adds_one: assert property (cycleDone && pcOp == ccs_pkg::CCS_PC_INC
        |-> ##2 programCounter == $past(programCounter) + 12'h001)
        else $error("pc step wrong");
    a_rel_adds_off: assert property (cycleDone && pcOp == ccs_pkg::CCS_PC_REL
        |-> ##2 programCounter == $past(programCounter) + $past(relExt, 2))
        else $error("rel sum wrong");
    a_irq_mode_entry: assert property (cycleDone && enterIrq && !enterNmi
        |-> ##2 modeOut == ccs_pkg::CCS_MODE_IRQ)
        else $error("irq pair not selected");
    a_nmi_mode_entry: assert property (cycleDone && enterNmi
        |-> ##2 modeOut == ccs_pkg::CCS_MODE_NMI)
        else $error("nmi pair not selected");
    a_map_hit: assert property (mapped |=> dataHit)
        else $error("no map hit");
    a_unmapped_zero: assert property (!mapped |=> !dataHit && dataRdData == 8'h00)
        else $error("miss not zero");
    a_arith_flags: assert property (cycleDone && noSwitch
        && flagOp == ccs_pkg::CCS_FL_ARITH |-> ##2 carryFlag == $past(aluCarry, 2)
        && zeroFlag == ($past(aluResult, 2) == 8'h00))
        else $error("arith flags wrong");
    a_btest_carry: assert property (cycleDone && noSwitch
        && flagOp == ccs_pkg::CCS_FL_BTEST |-> ##2 carryFlag == $past(testedBit, 2))
        else $error("bit test carry wrong");
    a_core_tick_period: assert property (machineTick
        |=> !machineTick [*8] ##1 !machineTick [*4] ##1 machineTick)
        else $error("core tick period");
    a_periph_tick_period: assert property (periphTick
        |=> !periphTick [*8] ##1 !periphTick [*3] ##1 periphTick)
        else $error("periph tick period");
    c_stack_full: cover property (stackFull);
    c_interrupt_return_instr: cover property (cycleDone && isReti);
    c_core_tick: cover property (machineTick);
endmodule
bind ccs_core_state ccs_core_state_chk #(.DEPTH(DEPTH)) ccs_core_state_chk_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .cycleDone(cycleDone),
    .pcOp(pcOp), .pcTarget(pcTarget), .relOffset(relOffset),
    .enterIrq(enterIrq), .enterNmi(enterNmi), .isReti(isReti),
    .dataAddr(dataAddr), .flagOp(flagOp), .aluResult(aluResult),
    .aluCarry(aluCarry), .testedBit(testedBit), .dataRdData(dataRdData),
    .dataHit(dataHit), .programCounter(programCounter),
    .carryFlag(carryFlag), .zeroFlag(zeroFlag), .modeOut(modeOut),
    .stackFull(stackFull), .machineTick(machineTick), .periphTick(periphTick));
`default_nettype wire

// [dv/tb_cpu_core_state_and_stack.sv]
// self-checking bench for core state and stack
// assumes the vector rom partner and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_core_state_and_stack;
    logic               core_clk, sys_rst, cycleDone, enterIrq, enterNmi;
    logic               isReti, dataWrEn, accWrEn, aluCarry, testedBit;
    logic [2:0]         instrCycles;
    logic [7:0]         relOffset, dataAddr, dataWrData, accWrData, aluResult;
    logic [11:0]        pcTarget, irqVector, nmiVector;
    ccs_pkg::ccs_pcop_t pcOp;
    ccs_pkg::ccs_flop_t flagOp;
    logic [7:0]         dataRdData, accumulator, pointerFirst, pointerSecond;
    logic [11:0]        programCounter;
    logic               dataHit, carryFlag, zeroFlag, stackFull, stackEmpty;
    logic               machineTick, periphTick, instrDone;
    ccs_pkg::ccs_mode_t modeOut;
    int                 failures, cmpCount, cycles;
    ccs_core_state ccs_core_state_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .cycleDone(cycleDone), .instrCycles(instrCycles), .pcOp(pcOp),
        .pcTarget(pcTarget), .relOffset(relOffset), .enterIrq(enterIrq),
        .enterNmi(enterNmi), .isReti(isReti), .dataWrEn(dataWrEn),
        .dataAddr(dataAddr), .dataWrData(dataWrData), .accWrEn(accWrEn),
        .accWrData(accWrData), .flagOp(flagOp), .aluResult(aluResult),
        .aluCarry(aluCarry), .testedBit(testedBit), .dataRdData(dataRdData),
        .dataHit(dataHit), .accumulator(accumulator),
        .pointerFirst(pointerFirst), .pointerSecond(pointerSecond),
        .programCounter(programCounter), .carryFlag(carryFlag),
        .zeroFlag(zeroFlag), .modeOut(modeOut), .stackFull(stackFull),
        .stackEmpty(stackEmpty), .machineTick(machineTick),
        .periphTick(periphTick), .instrDone(instrDone));
    ccs_vector_rom ccs_vector_rom_inst (.irqVector(irqVector),
        .nmiVector(nmiVector));
    always #5 core_clk = ~core_clk;
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    // commit, then idle one cycle
    task automatic commit(input ccs_pkg::ccs_pcop_t op,
                          input logic [11:0] t = 12'h000);
        pcOp = op;
        pcTarget = t;
        cycleDone = 1'b1;
        @(negedge core_clk);
        cycleDone = 1'b0;
        pcOp = ccs_pkg::CCS_PC_HOLD;
        flagOp = ccs_pkg::CCS_FL_NONE;
        {enterIrq, enterNmi, isReti} = 3'h0;
        @(negedge core_clk);
    endtask
    // extra idle edge between writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dataAddr = a;
        dataWrData = d;
        dataWrEn = 1'b1;
        @(negedge core_clk);
        dataWrEn = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] d);
        dataAddr = a;
        @(negedge core_clk);
        check({3'h0, dataHit, dataRdData}, {3'h0, h, d});
    endtask
    task automatic t_regs;
        logic [7:0] adr [5];
        adr = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
        for (int i = 0; i < 5; i++) wr(adr[i], 8'h11 * 8'(i + 1));
        for (int i = 0; i < 5; i++) rd(adr[i], 1'b1, 8'h11 * 8'(i + 1));
        rd(8'h84, 1'b0, 8'h00);
        check(12'(pointerFirst), 12'h011);
        check(12'(pointerSecond), 12'h022);
        check(12'(accumulator), 12'h055);
        accWrEn = 1'b1;
        accWrData = 8'h5a;
        wr(8'hff, 8'h66);
        accWrEn = 1'b0;
        check(12'(accumulator), 12'h05a);
        rd(8'hff, 1'b1, 8'h5a);
    endtask
    task automatic t_pc;
        check(12'(modeOut), 12'h004);
        commit(ccs_pkg::CCS_PC_INC);
        check(programCounter, 12'h001);
        commit(ccs_pkg::CCS_PC_JUMP, 12'habc);
        check(programCounter, 12'habc);
        relOffset = 8'h10;
        commit(ccs_pkg::CCS_PC_REL);
        check(programCounter, 12'hacc);
        relOffset = 8'hf0;
        commit(ccs_pkg::CCS_PC_REL);
        check(programCounter, 12'habc);
        commit(ccs_pkg::CCS_PC_JUMP, 12'hffe);
        relOffset = 8'h05;
        commit(ccs_pkg::CCS_PC_REL);
        check(programCounter, 12'h003);
    endtask
    // seven calls: oldest return lost
    task automatic t_stack;
        for (int i = 0; i < 7; i++) begin
            commit(ccs_pkg::CCS_PC_CALL, 12'h100 + 12'(i));
            if (i == 5) check(12'(stackFull), 12'h001);
        end
        check(programCounter, 12'h106);
        for (int i = 5; i >= 0; i--) begin
            commit(ccs_pkg::CCS_PC_RET);
            check(programCounter, 12'h100 + 12'(i));
        end
        commit(ccs_pkg::CCS_PC_RET);
        check(programCounter, 12'h101);
        check(12'(stackEmpty), 12'h001);
    endtask
    task automatic t_flags;
        flagOp = ccs_pkg::CCS_FL_ARITH;
        aluResult = 8'h01;
        aluCarry = 1'b1;
        commit(ccs_pkg::CCS_PC_HOLD);
        check(12'({carryFlag, zeroFlag}), 12'h002);
        enterIrq = 1'b1;
        commit(ccs_pkg::CCS_PC_VEC, irqVector);
        check(programCounter, 12'hff0);
        check({7'h00, modeOut, carryFlag, zeroFlag}, 12'h008);
        flagOp = ccs_pkg::CCS_FL_LOGIC;
        aluResult = 8'h00;
        commit(ccs_pkg::CCS_PC_HOLD);
        check(12'({carryFlag, zeroFlag}), 12'h001);
        flagOp = ccs_pkg::CCS_FL_BTEST;
        testedBit = 1'b1;
        commit(ccs_pkg::CCS_PC_HOLD);
        check(12'(carryFlag), 12'h001);
        flagOp = ccs_pkg::CCS_FL_ROTL;
        aluCarry = 1'b0;
        aluResult = 8'h02;
        commit(ccs_pkg::CCS_PC_HOLD);
        check(12'(carryFlag), 12'h000);
        enterNmi = 1'b1;
        commit(ccs_pkg::CCS_PC_VEC, nmiVector);
        check({7'h00, modeOut, carryFlag, zeroFlag}, 12'h012);
        isReti = 1'b1;
        commit(ccs_pkg::CCS_PC_RET);
        check({7'h00, modeOut, carryFlag, 1'b0}, 12'h008);
        check(programCounter, 12'hff0);
        isReti = 1'b1;
        commit(ccs_pkg::CCS_PC_RET);
        check({7'h00, modeOut, carryFlag, zeroFlag}, 12'h012);
        check(programCounter, 12'h101);
    endtask
    task automatic wrap_up;
        if (failures == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // inputs move on falling edges
    initial begin
        {core_clk, cycleDone, enterIrq, enterNmi, isReti} = 5'h00;
        {dataWrEn, accWrEn, aluCarry, testedBit} = 4'h0;
        {relOffset, dataAddr, dataWrData, accWrData, aluResult} = 40'h0;
        {failures, cmpCount, cycles} = 0;
        sys_rst = 1'b1;
        instrCycles = 3'h4;
        pcTarget = 12'h000;
        pcOp = ccs_pkg::CCS_PC_HOLD;
        flagOp = ccs_pkg::CCS_FL_NONE;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_pc();
        t_regs();
        t_stack();
        t_flags();
        wrap_up();
    end
endmodule
`default_nettype wire
